// [design/imsk_pkg.sv]
/*
  package for the interrupt mask slice, bits 12 to 21.
  assumes one 50 MHz core clock, synchronous active-high reset.
*/
// Overview of operation
// RULE1: bit 21 gates circular buffer 15 overflow
// RULE2: bit 20 gates restricted sequence interrupt
// RULE3: bit 16 gates iir channel 1 done
// RULE4: bit 15 gates system event interrupt
// RULE5: self nesting keeps system event unmasked
// RULE6: preempted system event service becomes masked
// RULE7: bit 14 gates iir channel 0 done
// RULE8: bit 13 gates fir channel done
// RULE9: bit 12 gates hardware breakpoint
// RULE10: masked sources still latch, served later
// RULE11: mask bits align with latch bits
// RULE12: bits 17 to 19 reserved, read zero
`default_nettype none
package imsk_pkg;
  localparam int unsigned BIT_BKP   = 12;
  localparam int unsigned BIT_FIR   = 13;
  localparam int unsigned BIT_IIR0  = 14;
  localparam int unsigned BIT_SEV   = 15;
  localparam int unsigned BIT_IIR1  = 16;
  localparam int unsigned BIT_RSEQ  = 20;
  localparam int unsigned BIT_CB15  = 21;
  localparam logic [31:0] SLICE_MSK = 32'h0031F000;
  localparam logic [3:0] ADR_MASK   = 4'h0;
  localparam logic [3:0] ADR_LATCH  = 4'h1;
  localparam logic [3:0] ADR_MODE   = 4'h2;
  localparam logic [3:0] ADR_ISTAT  = 4'h3;
  localparam logic [3:0] ADR_IMSK   = 4'h4;
  localparam logic [31:0] RST_MASK  = 32'h00000000;
  localparam logic [1:0] RST_MODE   = 2'h0;
  localparam logic [31:0] RST_LATCH = 32'h00000000;
  localparam logic [31:0] RST_RDATA = 32'h00000000;
  localparam logic [1:0] RST_STAT   = 2'h0;

  typedef struct packed {
    logic [31:0] addr_unused_hi;
  } imsk_dummy_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } imsk_bus_t;

  typedef enum logic [2:0] {
    SV_IDLE = 3'b001,
    SV_SERV = 3'b010,
    SV_PRE  = 3'b100
  } imsk_sev_t;
endpackage
`default_nettype wire

// [design/imsk_top.sv]
/*
  mask slice bits 12..21 with latch, nesting handling and register port.
  assumes the sequencer reports service start/end of the system event
  and preemption by a higher source; strobes are one cycle wide.
*/
`default_nettype none
module imsk_top #(
  parameter int unsigned DW = 32
) (
  input  wire logic          sys_clk_i,
  input  wire logic          srst_i,
  input  wire logic [3:0]    addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  input  wire logic [DW-1:0] src_irq_i,
  input  wire logic          sev_svc_start_i,
  input  wire logic          sev_svc_end_i,
  input  wire logic          sev_preempt_i,
  input  wire logic [DW-1:0] ack_i,
  output logic      [DW-1:0] rdata_o,
  output logic      [DW-1:0] pending_o,
  output logic               sev_serving_o,
  output logic               irq_o
);
  imsk_pkg::imsk_bus_t bus;
  imsk_pkg::imsk_sev_t st_q, st_d;
  logic [DW-1:0] mask_q, mask_d, latch_q, latch_d, pend_q, pend_d, rd_q, rd_d;
  logic [DW-1:0] eff;
  logic [1:0]    mode_q, mode_d;
  logic [1:0]    ist_q, ist_d, iem_q, iem_d;
  logic          irq_q, irq_d, nest, self_ok;
  logic          serv_q, serv_d;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  assign bus  = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign nest = mode_q[0] & mode_q[1];
  assign self_ok = nest & (st_q == imsk_pkg::SV_SERV);

  // system event service tracking
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      imsk_pkg::SV_IDLE: if (sev_svc_start_i) st_d = imsk_pkg::SV_SERV;
      imsk_pkg::SV_SERV:
      begin
        if (sev_svc_end_i) st_d = imsk_pkg::SV_IDLE;
        else if (sev_preempt_i) st_d = imsk_pkg::SV_PRE; // RULE6
      end
      imsk_pkg::SV_PRE: if (sev_svc_end_i) st_d = imsk_pkg::SV_IDLE;
      default: st_d = imsk_pkg::SV_IDLE;
    endcase
    serv_d = (st_d != imsk_pkg::SV_IDLE);
  end

  // effective mask: during service only self nesting may reopen the event
  always_comb
  begin
    eff = mask_q & imsk_pkg::SLICE_MSK; // RULE1 RULE2 RULE3 RULE4 RULE7 RULE8 RULE9 RULE12
    if (st_q != imsk_pkg::SV_IDLE)
    begin
      eff = '0; // lower priority sources held off while serving
      eff[imsk_pkg::BIT_SEV] = self_ok & mask_q[imsk_pkg::BIT_SEV]; // RULE5 RULE6
    end
  end

  // registers; a hardware set beats a same-cycle clear
  always_comb
  begin
    mask_d = mask_q;
    mode_d = mode_q;
    iem_d  = iem_q;
    latch_d = latch_q & ~ack_i;
    if (bus.wr && hit(bus.addr, imsk_pkg::ADR_MASK))
      mask_d = bus.wdata & imsk_pkg::SLICE_MSK; // RULE12
    if (bus.wr && hit(bus.addr, imsk_pkg::ADR_LATCH))
      latch_d = latch_d & ~bus.wdata;
    if (bus.wr && hit(bus.addr, imsk_pkg::ADR_MODE))
      mode_d = bus.wdata[1:0];
    if (bus.wr && hit(bus.addr, imsk_pkg::ADR_IMSK))
      iem_d = bus.wdata[1:0];
    latch_d = (latch_d | src_irq_i) & imsk_pkg::SLICE_MSK; // RULE10 RULE11
    pend_d  = latch_d & eff; // RULE10
    ist_d = ist_q;
    if (bus.wr && hit(bus.addr, imsk_pkg::ADR_ISTAT))
      ist_d = ist_q & ~bus.wdata[1:0];
    ist_d = ist_d | {sev_preempt_i & (st_q == imsk_pkg::SV_SERV), |(src_irq_i & imsk_pkg::SLICE_MSK & ~mask_q)};
    irq_d = |(ist_d & iem_d);
    rd_d = '0;
    if (bus.rd)
      case (bus.addr)
        imsk_pkg::ADR_MASK:  rd_d = mask_q;
        imsk_pkg::ADR_LATCH: rd_d = latch_q;
        imsk_pkg::ADR_MODE:  rd_d = {28'h0000000, st_q == imsk_pkg::SV_PRE, st_q == imsk_pkg::SV_SERV, mode_q};
        imsk_pkg::ADR_ISTAT: rd_d = {30'h00000000, ist_q};
        imsk_pkg::ADR_IMSK:  rd_d = {30'h00000000, iem_q};
        default:             rd_d = '0;
      endcase
  end

  // service state; the serving flag has its own flop so the pin has no decode behind it
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      st_q   <= imsk_pkg::SV_IDLE;
      serv_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      serv_q <= serv_d;
    end
  end

  // software configuration
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      mask_q <= imsk_pkg::RST_MASK;
      mode_q <= imsk_pkg::RST_MODE;
      iem_q  <= imsk_pkg::RST_STAT;
    end
    else
    begin
      mask_q <= mask_d;
      mode_q <= mode_d;
      iem_q  <= iem_d;
    end
  end

  // latch and its gated view
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      latch_q <= imsk_pkg::RST_LATCH;
      pend_q  <= imsk_pkg::RST_LATCH;
    end
    else
    begin
      latch_q <= latch_d;
      pend_q  <= pend_d;
    end
  end

  // status flags and the interrupt line
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      ist_q <= imsk_pkg::RST_STAT;
      irq_q <= 1'b0;
    end
    else
    begin
      ist_q <= ist_d;
      irq_q <= irq_d;
    end
  end

  // read data; zero outside the answer cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      rd_q <= imsk_pkg::RST_RDATA;
    else
      rd_q <= rd_d;
  end

  assign rdata_o       = rd_q;
  assign pending_o     = pend_q;
  assign sev_serving_o = serv_q;
  assign irq_o         = irq_q;

  // register access and reserved positions
  reserved_zero_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE12
    (mask_q[19:17] == 3'h0) && (latch_q[19:17] == 3'h0))
    else $error("reserved bits set");
  reserved_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE12
    (rd_i && addr_i == imsk_pkg::ADR_MASK) |=> rdata_o[19:17] == 3'h0)
    else $error("reserved bits read back");
  mask_write_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE1
    (wr_i && addr_i == imsk_pkg::ADR_MASK) |=> mask_q == ($past(wdata_i) & imsk_pkg::SLICE_MSK))
    else $error("mask write lost");
  mask_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE11
    (rd_i && addr_i == imsk_pkg::ADR_MASK) |=> rdata_o == $past(mask_q))
    else $error("mask read wrong");
  latch_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE11
    (rd_i && addr_i == imsk_pkg::ADR_LATCH) |=> rdata_o == $past(latch_q))
    else $error("latch read wrong");
  mode_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE5
    (rd_i && addr_i == imsk_pkg::ADR_MODE) |=> rdata_o[1:0] == $past(mode_q))
    else $error("mode read wrong");

  // a clear mask bit keeps its source off the pending lines
  cb15_gate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE1
    !mask_q[imsk_pkg::BIT_CB15] |=> !pending_o[imsk_pkg::BIT_CB15])
    else $error("overflow source pending while masked");
  gate_closed_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE2
    !mask_q[imsk_pkg::BIT_RSEQ] |=> !pending_o[imsk_pkg::BIT_RSEQ] || $past(wr_i))
    else $error("masked source pending");
  iir1_gate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE3
    !mask_q[imsk_pkg::BIT_IIR1] |=> !pending_o[imsk_pkg::BIT_IIR1])
    else $error("iir channel 1 pending while masked");
  sev_gate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE4
    !mask_q[imsk_pkg::BIT_SEV] |=> !pending_o[imsk_pkg::BIT_SEV])
    else $error("system event pending while masked");
  iir0_gate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE7
    !mask_q[imsk_pkg::BIT_IIR0] |=> !pending_o[imsk_pkg::BIT_IIR0])
    else $error("iir channel 0 pending while masked");
  fir_gate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE8
    !mask_q[imsk_pkg::BIT_FIR] |=> !pending_o[imsk_pkg::BIT_FIR])
    else $error("fir channel pending while masked");
  bkp_gate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE9
    !mask_q[imsk_pkg::BIT_BKP] |=> !pending_o[imsk_pkg::BIT_BKP])
    else $error("breakpoint pending while masked");

  // a set mask bit passes a fresh or latched request while no event is in service
  cb15_open_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE1
    (st_q == imsk_pkg::SV_IDLE && src_irq_i[imsk_pkg::BIT_CB15] && mask_q[imsk_pkg::BIT_CB15])
    |=> pending_o[imsk_pkg::BIT_CB15]) else $error("overflow source blocked while unmasked");
  rseq_open_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE2
    (st_q == imsk_pkg::SV_IDLE && src_irq_i[imsk_pkg::BIT_RSEQ] && mask_q[imsk_pkg::BIT_RSEQ])
    |=> pending_o[imsk_pkg::BIT_RSEQ]) else $error("sequence source blocked while unmasked");
  iir1_open_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE3
    (st_q == imsk_pkg::SV_IDLE && src_irq_i[imsk_pkg::BIT_IIR1] && mask_q[imsk_pkg::BIT_IIR1])
    |=> pending_o[imsk_pkg::BIT_IIR1]) else $error("iir channel 1 blocked while unmasked");
  sev_open_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE4
    (st_q == imsk_pkg::SV_IDLE && src_irq_i[imsk_pkg::BIT_SEV] && mask_q[imsk_pkg::BIT_SEV])
    |=> pending_o[imsk_pkg::BIT_SEV]) else $error("system event blocked while unmasked");
  iir0_open_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE7
    (st_q == imsk_pkg::SV_IDLE && src_irq_i[imsk_pkg::BIT_IIR0] && mask_q[imsk_pkg::BIT_IIR0])
    |=> pending_o[imsk_pkg::BIT_IIR0]) else $error("iir channel 0 blocked while unmasked");
  unmask_pend_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE8
    (st_q == imsk_pkg::SV_IDLE && latch_q[imsk_pkg::BIT_FIR] && mask_q[imsk_pkg::BIT_FIR]
     && !ack_i[imsk_pkg::BIT_FIR] && !wr_i) |=> pending_o[imsk_pkg::BIT_FIR]) else $error("no pending");
  bkp_open_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE9
    (st_q == imsk_pkg::SV_IDLE && src_irq_i[imsk_pkg::BIT_BKP] && mask_q[imsk_pkg::BIT_BKP])
    |=> pending_o[imsk_pkg::BIT_BKP]) else $error("breakpoint blocked while unmasked");

  // latch keeps masked requests until acknowledged or cleared
  masked_latch_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE10
    (src_irq_i[imsk_pkg::BIT_BKP] && !mask_q[imsk_pkg::BIT_BKP]) |=> latch_q[imsk_pkg::BIT_BKP])
    else $error("masked source not latched");
  cb15_latch_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE10
    (src_irq_i[imsk_pkg::BIT_CB15] && !mask_q[imsk_pkg::BIT_CB15]) |=> latch_q[imsk_pkg::BIT_CB15])
    else $error("masked overflow not latched");
  sev_latch_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE10
    (src_irq_i[imsk_pkg::BIT_SEV] && !mask_q[imsk_pkg::BIT_SEV]) |=> latch_q[imsk_pkg::BIT_SEV])
    else $error("masked system event not latched");
  rseq_latch_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE10
    (src_irq_i[imsk_pkg::BIT_RSEQ] && !mask_q[imsk_pkg::BIT_RSEQ]) |=> latch_q[imsk_pkg::BIT_RSEQ])
    else $error("masked sequence source not latched");
  iir0_latch_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE10
    (src_irq_i[imsk_pkg::BIT_IIR0] && !mask_q[imsk_pkg::BIT_IIR0]) |=> latch_q[imsk_pkg::BIT_IIR0])
    else $error("masked iir channel 0 not latched");
  latch_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE10
    (latch_q[imsk_pkg::BIT_BKP] && !ack_i[imsk_pkg::BIT_BKP] && !wr_i) |=> latch_q[imsk_pkg::BIT_BKP])
    else $error("latched request lost");
  ack_clear_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE10
    (ack_i[imsk_pkg::BIT_FIR] && !src_irq_i[imsk_pkg::BIT_FIR]) |=> !latch_q[imsk_pkg::BIT_FIR])
    else $error("acknowledge did not clear");
  pend_align_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE11
    (pending_o & ~latch_q) == '0)
    else $error("pending bit without latch bit");
  status_set_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE10
    (src_irq_i[imsk_pkg::BIT_BKP] && !mask_q[imsk_pkg::BIT_BKP]) |=> ist_q[0])
    else $error("masked arrival not flagged");
  irq_level_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE10
    irq_o == |(ist_q & iem_q))
    else $error("interrupt line disagrees with status");

  // system event service; lower sources wait because priority lives outside
  self_nest_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE5
    (self_ok && mask_q[imsk_pkg::BIT_SEV] && latch_d[imsk_pkg::BIT_SEV]) |=> pending_o[imsk_pkg::BIT_SEV])
    else $error("self nest blocked");
  nest_off_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE5
    (st_q != imsk_pkg::SV_IDLE && !nest) |=> !pending_o[imsk_pkg::BIT_SEV])
    else $error("system event reopened without nesting");
  preempt_mask_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE6
    (st_q == imsk_pkg::SV_PRE) |=> !pending_o[imsk_pkg::BIT_SEV])
    else $error("preempted event open");
  preempt_enter_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE6
    (st_q == imsk_pkg::SV_SERV && sev_preempt_i && !sev_svc_end_i) |=> st_q == imsk_pkg::SV_PRE)
    else $error("preemption not taken");
  lower_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE5
    (st_q != imsk_pkg::SV_IDLE) |=> (pending_o[imsk_pkg::BIT_CB15] == 1'b0) || $past(st_q) == imsk_pkg::SV_IDLE)
    else $error("lower source open in service");
  lower_fir_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE5
    (st_q != imsk_pkg::SV_IDLE) |=> !pending_o[imsk_pkg::BIT_FIR])
    else $error("fir channel open in service");
  lower_bkp_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE5
    (st_q != imsk_pkg::SV_IDLE) |=> !pending_o[imsk_pkg::BIT_BKP])
    else $error("breakpoint open in service");
  serving_flag_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE6
    (st_q == imsk_pkg::SV_PRE && !sev_svc_end_i) |=> sev_serving_o)
    else $error("serving flag dropped while preempted");
  state_onehot_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE6
    $onehot(st_q))
    else $error("service state not one-hot");
endmodule
`default_nettype wire

// [testbench/imsk_seq_model.sv]
/* source and sequencer model for the mask slice.
   assumes one-cycle commands from the bench. */
`default_nettype none
module imsk_seq_model (
  input  wire logic        sys_clk_i,
  input  wire logic [31:0] fire_i,
  input  wire logic [1:0]  cmd_i,
  output logic      [31:0] src_o,
  output logic             start_o,
  output logic             pre_o,
  output logic             end_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // pulses launched after the edge, one cycle wide like the sequencer
  always @(posedge sys_clk_i)
  begin
    src_o <= fire_i;
    start_o <= (cmd_i == 2'h1);
    pre_o <= (cmd_i == 2'h2);
    end_o <= (cmd_i == 2'h3);
  end
endmodule
`default_nettype wire

// [testbench/imsk_tb_top.sv]
/* self-checking bench for the mask slice.
   assumes imsk_seq_model drives sources and service strobes. */
`default_nettype none
module imsk_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] a = 4'h0;
  logic [31:0] wd = '0, fire = '0, ack = '0, mv;
  logic wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic [31:0] src, rdata, pend;
  logic st, pre, en, serv, irq;
  logic [31:0] expq[$];
  int mismatches = 0, cmp_count = 0, cyc = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  imsk_top imsk_top_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(a), .wdata_i(wd), .wr_i(wr),
    .rd_i(rd), .src_irq_i(src), .sev_svc_start_i(st), .sev_svc_end_i(en), .sev_preempt_i(pre),
    .ack_i(ack), .rdata_o(rdata), .pending_o(pend), .sev_serving_o(serv), .irq_o(irq));
  imsk_seq_model imsk_seq_model_i (.sys_clk_i(sys_clk_i), .fire_i(fire), .cmd_i(cmd), .src_o(src),
    .start_o(st), .pre_o(pre), .end_o(en));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // write d, or read and note d as the expected data
  task automatic acc(input logic w, input logic [3:0] ad, input logic [31:0] d);
    wr <= w;
    rd <= !w;
    a <= ad;
    wd <= d;
    if (!w)
      expq.push_back(d);
    tick(1);
    wr <= 1'b0;
    rd <= 1'b0;
    // idle edge so the next access never reassigns a strobe in this step
    tick(1);
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge sys_clk_i)
  begin
    rd_q <= rd;
    cyc++;
    if (rd_q)
      chk(rdata, expq.pop_front());
    if (cyc > 2000)
    begin
      mismatches++;
      complete_run();
    end
  end
  initial
  begin
    void'($urandom(17797));
    tick(10);
    srst_i <= 1'b0;
    acc(1'b0, imsk_pkg::ADR_MASK, imsk_pkg::RST_MASK);
    repeat (6)
    begin
      mv = $urandom();
      acc(1'b1, imsk_pkg::ADR_MASK, mv);
      acc(1'b0, imsk_pkg::ADR_MASK, mv & imsk_pkg::SLICE_MSK);
    end
    acc(1'b0, 4'hF, 32'h0);
    $display("test mask access done");
    acc(1'b1, imsk_pkg::ADR_MASK, 32'h0);
    acc(1'b1, imsk_pkg::ADR_LATCH, 32'hFFFFFFFF);
    acc(1'b1, imsk_pkg::ADR_ISTAT, 32'h3);
    fire <= $urandom() | imsk_pkg::SLICE_MSK;
    tick(1);
    fire <= 32'h0;
    acc(1'b1, imsk_pkg::ADR_IMSK, 32'h1);
    tick(2);
    chk(pend, 32'h0);
    chk({31'h0, irq}, 32'h1);
    acc(1'b0, imsk_pkg::ADR_LATCH, imsk_pkg::SLICE_MSK);
    acc(1'b1, imsk_pkg::ADR_ISTAT, 32'h1);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, imsk_pkg::ADR_MASK, imsk_pkg::SLICE_MSK);
    tick(2);
    chk(pend, imsk_pkg::SLICE_MSK);
    $display("test latch and irq done");
    acc(1'b1, imsk_pkg::ADR_MODE, 32'h3);
    cmd <= 2'h1;
    tick(1);
    cmd <= 2'h0;
    tick(3);
    chk(pend, 32'h00008000);
    chk({31'h0, serv}, 32'h1);
    cmd <= 2'h2;
    tick(1);
    cmd <= 2'h0;
    tick(3);
    chk(pend, 32'h0);
    $display("test nesting done");
    acc(1'b0, imsk_pkg::ADR_MODE, 32'h0000000B);
    acc(1'b0, imsk_pkg::ADR_ISTAT, 32'h00000002);
    acc(1'b0, imsk_pkg::ADR_IMSK, 32'h00000001);
    cmd <= 2'h3;
    tick(1);
    cmd <= 2'h0;
    tick(3);
    chk({31'h0, serv}, 32'h0);
    chk(pend, imsk_pkg::SLICE_MSK);
    ack <= 32'h00001000;
    tick(1);
    ack <= 32'h0;
    acc(1'b0, imsk_pkg::ADR_LATCH, imsk_pkg::SLICE_MSK & ~32'h00001000);
    chk(pend, imsk_pkg::SLICE_MSK & ~32'h00001000);
    $display("test service end and acknowledge done");
    complete_run();
  end
endmodule
`default_nettype wire
